// ==== ocm_pkg.sv ====
/*
  package for the output compare channel: mode codes, control field layout,
  reset values and the carrier structs shared by the channel modules.
  assumes a single 200 MHz clock and an active-low asynchronous reset.
*/
// How it works
// - three-bit mode field selects eight channel modes
// - faulted pwm entry: pin low if compare zero
// - faulted pwm interrupts on fault input falling edge
// - plain pwm starts by compare value, no interrupt
// - toggle entry keeps the current pin level
// - toggle interrupts on both pin edges
// - mode zero releases pin, no interrupt
package ocm_pkg;

  localparam int CTRL_W       = 16;
  localparam int CMP_W        = 16;
  localparam int MODE_LSB     = 0;
  localparam int MODE_MSB     = 2;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 16'h0000;
  localparam logic              PIN_RESET  = 1'b0;

  typedef enum logic [2:0] {
    OCM_OFF        = 3'h0,
    OCM_ONE_LOW    = 3'h1,
    OCM_ONE_HIGH   = 3'h2,
    OCM_TOGGLE     = 3'h3,
    OCM_DELAY_ONE  = 3'h4,
    OCM_PULSE      = 3'h5,
    OCM_PWM        = 3'h6,
    OCM_PWM_FAULT  = 3'h7
  } ocm_mode_t;

  // which pin or fault edges raise the channel interrupt
  typedef struct packed {
    logic pin_rise;
    logic pin_fall;
    logic fault_fall;
  } ocm_irq_sel_t;

  // output drive of the channel toward the pin mux
  typedef struct packed {
    logic drive;
    logic level;
  } ocm_pin_t;

endpackage

// ==== ocm_edge_irq.sv ====
/*
  edge detector that turns selected pin and fault-input edges into a
  one-cycle interrupt pulse.
  assumes inputs already synchronous to clk.
*/
`timescale 1ns/100ps
module ocm_edge_irq (
  input  wire logic               clk,
  input  wire logic               arst_n,
  input  wire ocm_pkg::ocm_irq_sel_t sel,
  input  wire logic               pin_level,
  input  wire logic               fault_a,
  output logic                    irq_pulse_r
);

  logic pin_d_r;
  logic fault_d_r;
  logic irq_nxt;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_d_r   <= ocm_pkg::PIN_RESET;
      fault_d_r <= 1'b1;
    end else begin
      pin_d_r   <= pin_level;
      fault_d_r <= fault_a;
    end
  end

  always_comb begin
    irq_nxt = (sel.pin_rise & pin_level & ~pin_d_r)
            | (sel.pin_fall & ~pin_level & pin_d_r)
            | (sel.fault_fall & ~fault_a & fault_d_r);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) irq_pulse_r <= 1'b0;
    else irq_pulse_r <= irq_nxt;
  end

endmodule

// ==== ocm_channel.sv ====
/*
  output compare channel mode logic: decodes the mode field of the control
  word, sets the pin's initial level on mode entry, drives the pin from the
  timer compare events and raises the channel interrupt on the mode's edges.
  assumes the time base and compare match strobes come from a timer outside,
  and that software stops that timer while it rewrites the control word.
*/
`timescale 1ns/100ps
module ocm_channel (
  input  wire logic                       clk,
  input  wire logic                       arst_n,
  input  wire logic [ocm_pkg::CTRL_W-1:0] compare_control_reg,
  input  wire logic [ocm_pkg::CMP_W-1:0]  primary_compare_value,
  input  wire logic                       match_primary,
  input  wire logic                       match_secondary,
  input  wire logic                       period_end,
  input  wire logic                       fault_input_a,
  output ocm_pkg::ocm_pin_t               compare_output_pin,
  output logic                            channel_irq
);

  // ----------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------
  ocm_pkg::ocm_mode_t mode;
  ocm_pkg::ocm_mode_t mode_r;
  logic               entry;
  logic               entry_d_r;
  logic               level_r;
  logic               level_nxt;
  logic               drive_r;
  logic               fired_r;
  logic               cmp_zero;
  ocm_pkg::ocm_irq_sel_t sel;

  assign mode     = ocm_pkg::ocm_mode_t'(
                      compare_control_reg[ocm_pkg::MODE_MSB:ocm_pkg::MODE_LSB]);
  assign entry    = (mode != mode_r);
  assign cmp_zero = (primary_compare_value == '0);

  function automatic ocm_pkg::ocm_irq_sel_t irq_sel(input ocm_pkg::ocm_mode_t m);
    ocm_pkg::ocm_irq_sel_t s;
    s = '0;
    unique case (m)
      ocm_pkg::OCM_OFF:       s = '0;
      ocm_pkg::OCM_ONE_LOW:   s.pin_rise = 1'b1;
      ocm_pkg::OCM_ONE_HIGH:  s.pin_fall = 1'b1;
      ocm_pkg::OCM_TOGGLE: begin
        s.pin_rise = 1'b1;
        s.pin_fall = 1'b1;
      end
      ocm_pkg::OCM_DELAY_ONE,
      ocm_pkg::OCM_PULSE:     s.pin_fall = 1'b1;
      ocm_pkg::OCM_PWM:       s = '0;
      ocm_pkg::OCM_PWM_FAULT: s.fault_fall = 1'b1;
    endcase
    return s;
  endfunction

  // ----------------------------------------------------------------
  // mode tracking and one-shot state
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) mode_r <= ocm_pkg::OCM_OFF;
    else mode_r <= mode;
  end

  // remembers the entry edge so the entry level change is never taken as an event
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) entry_d_r <= 1'b0;
    else entry_d_r <= entry;
  end

  // one-shot modes fire once per mode entry
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) fired_r <= 1'b0;
    else if (entry) fired_r <= 1'b0;
    else if (mode == ocm_pkg::OCM_DELAY_ONE && match_secondary) fired_r <= 1'b1;
    else if ((mode == ocm_pkg::OCM_ONE_LOW || mode == ocm_pkg::OCM_ONE_HIGH)
             && match_primary) fired_r <= 1'b1;
  end

  // ----------------------------------------------------------------
  // pin level
  // ----------------------------------------------------------------
  always_comb begin
    level_nxt = level_r;
    unique case (mode)
      ocm_pkg::OCM_OFF:       level_nxt = ocm_pkg::PIN_RESET;
      // OCM_ONE_LOW and OCM_ONE_HIGH pulses last one cycle, then the pin returns to its idle level
      ocm_pkg::OCM_ONE_LOW: begin
        if (entry) level_nxt = 1'b1;
        else if (match_primary && !fired_r) level_nxt = 1'b0;
        else if (fired_r) level_nxt = 1'b1;
      end
      ocm_pkg::OCM_ONE_HIGH: begin
        if (entry) level_nxt = 1'b0;
        else if (match_primary && !fired_r) level_nxt = 1'b1;
        else if (fired_r) level_nxt = 1'b0;
      end
      ocm_pkg::OCM_TOGGLE: begin
        if (!entry && match_primary) level_nxt = ~level_r;
      end
      ocm_pkg::OCM_DELAY_ONE: begin
        if (entry) level_nxt = 1'b0;
        else if (match_primary && !fired_r) level_nxt = 1'b1;
        else if (match_secondary) level_nxt = 1'b0;
      end
      ocm_pkg::OCM_PULSE: begin
        if (entry) level_nxt = 1'b0;
        else if (match_primary) level_nxt = 1'b1;
        else if (match_secondary) level_nxt = 1'b0;
      end
      // pwm reloads on each period end, so a zero compare value keeps the pin low
      ocm_pkg::OCM_PWM,
      ocm_pkg::OCM_PWM_FAULT: begin
        if (entry) level_nxt = !cmp_zero;
        else if (period_end) level_nxt = !cmp_zero;
        else if (match_primary) level_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) level_r <= ocm_pkg::PIN_RESET;
    else level_r <= level_nxt;
  end

  // disabled channel hands the pin back to the port logic
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) drive_r <= 1'b0;
    else drive_r <= (mode != ocm_pkg::OCM_OFF);
  end

  assign compare_output_pin.drive = drive_r;
  assign compare_output_pin.level = level_r;

  // ----------------------------------------------------------------
  // interrupt edges
  // ----------------------------------------------------------------
  // the entry level lands one edge after the mode change and reaches the
  // detector a cycle later, so pin edges stay masked for that cycle too;
  // fault edges stay live there, the fault input does not move on entry
  always_comb begin
    sel = irq_sel(mode_r);
    if (entry) sel = '0;
    if (entry_d_r) begin
      sel.pin_rise = 1'b0;
      sel.pin_fall = 1'b0;
    end
  end

  ocm_edge_irq u_irq (
    .clk         (clk),
    .arst_n      (arst_n),
    .sel         (sel),
    .pin_level   (level_r),
    .fault_a     (fault_input_a),
    .irq_pulse_r (channel_irq)
  );

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  // all properties run on the one clock and are muted during reset
  a_off_no_irq: assert property (@(posedge clk) disable iff (!arst_n)
    (mode_r == ocm_pkg::OCM_OFF && $past(mode_r) == ocm_pkg::OCM_OFF) |-> ##1 !channel_irq)
    else $error("irq while disabled");
  a_off_release: assert property (@(posedge clk) disable iff (!arst_n)
    (mode == ocm_pkg::OCM_OFF) |=> !compare_output_pin.drive)
    else $error("pin driven while disabled");
  a_pwmf_entry: assert property (@(posedge clk) disable iff (!arst_n)
    (mode == ocm_pkg::OCM_PWM_FAULT && entry) |=> (level_r == !$past(cmp_zero)))
    else $error("faulted pwm initial level wrong");
  a_pwm_entry: assert property (@(posedge clk) disable iff (!arst_n)
    (mode == ocm_pkg::OCM_PWM && entry) |=> (level_r == !$past(cmp_zero)))
    else $error("pwm initial level wrong");
  a_pwm_no_irq: assert property (@(posedge clk) disable iff (!arst_n)
    (mode_r == ocm_pkg::OCM_PWM && mode == ocm_pkg::OCM_PWM) |=> !channel_irq)
    else $error("irq in plain pwm");
  a_toggle_keep: assert property (@(posedge clk) disable iff (!arst_n)
    (mode == ocm_pkg::OCM_TOGGLE && entry) |=> $stable(level_r))
    else $error("toggle entry changed pin");
  a_toggle_irq: assert property (@(posedge clk) disable iff (!arst_n)
    (mode_r == ocm_pkg::OCM_TOGGLE && !entry && match_primary) |=> ##1 channel_irq)
    else $error("toggle edge missed irq");
  a_fault_irq: assert property (@(posedge clk) disable iff (!arst_n)
    (mode_r == ocm_pkg::OCM_PWM_FAULT && !entry && $fell(fault_input_a)) |=> channel_irq)
    else $error("fault edge missed irq");
  a_oneshot_low: assert property (@(posedge clk) disable iff (!arst_n)
    (mode == ocm_pkg::OCM_ONE_LOW && entry) |=> level_r)
    else $error("active-low one-shot not started high");
  a_mode_decode: assert property (@(posedge clk) disable iff (!arst_n)
    1'b1 |=> (mode_r == $past(compare_control_reg[2:0])))
    else $error("mode field decode wrong");

  // entry levels of the remaining modes, the active-low one-shot return to idle and the masked entry edge
  a_oneshot_high: assert property (@(posedge clk) disable iff (!arst_n)
    (mode == ocm_pkg::OCM_ONE_HIGH && entry) |=> !level_r)
    else $error("active-high one-shot not started low");
  a_delay_start: assert property (@(posedge clk) disable iff (!arst_n)
    ((mode == ocm_pkg::OCM_DELAY_ONE || mode == ocm_pkg::OCM_PULSE) && entry) |=> !level_r)
    else $error("delayed or pulse mode not started low");
  a_shot_return: assert property (@(posedge clk) disable iff (!arst_n)
    (mode_r == ocm_pkg::OCM_ONE_LOW && !entry && fired_r) |=> level_r)
    else $error("active-low one-shot did not return high");
  a_entry_no_irq: assert property (@(posedge clk) disable iff (!arst_n)
    (entry && mode != ocm_pkg::OCM_PWM_FAULT) |=> !channel_irq ##1 !channel_irq)
    else $error("irq raised by a mode entry");

  // main scenarios

  c_toggle: cover property (@(posedge clk) disable iff (!arst_n)
    mode_r == ocm_pkg::OCM_TOGGLE && channel_irq);
  c_fault: cover property (@(posedge clk) disable iff (!arst_n)
    mode_r == ocm_pkg::OCM_PWM_FAULT && channel_irq);
  c_pulse: cover property (@(posedge clk) disable iff (!arst_n)
    mode_r == ocm_pkg::OCM_PULSE && $fell(level_r));
  c_delay: cover property (@(posedge clk) disable iff (!arst_n)
    mode_r == ocm_pkg::OCM_DELAY_ONE && fired_r);
  c_oneshot: cover property (@(posedge clk) disable iff (!arst_n)
    mode_r == ocm_pkg::OCM_ONE_LOW && channel_irq);

endmodule

// ==== ocm_pin_load.sv ====
/*
  partner model: the board node behind the compare output pin.
  assumes the port register level stands in whenever the channel lets go.
*/
`timescale 1ns/100ps
module ocm_pin_load (
  input  wire ocm_pkg::ocm_pin_t pin,
  input  wire logic              gpio_level,
  output logic                   wire_level
);
  // ----------------------------------------
  // pin resolution
  // ----------------------------------------
  // a released pin shows the port register, never the last channel level
  assign wire_level = pin.drive ? pin.level : gpio_level;
endmodule

// ==== ocm_channel_test.sv ====
/*
  self-checking bench for the output compare channel: mode entry levels,
  toggle, delayed one-shot, fault and pwm interrupt behaviour.
  assumes the timer strobes stay low whenever the mode field changes.
*/
`timescale 1ns/100ps
module ocm_channel_test;
  logic              clk;
  logic              arst_n;
  logic [15:0]       ctrl;
  logic [15:0]       cmp_val;
  logic              m_pri;
  logic              m_sec;
  logic              p_end;
  logic              fault_a;
  logic              gpio_level;
  ocm_pkg::ocm_pin_t pin;
  logic              irq;
  logic              wire_level;
  int                bad_count;
  int                check_count;
  int                c;
  logic [2:0]        modes [6] = '{3'h1, 3'h2, 3'h4, 3'h5, 3'h6, 3'h7};

  ocm_channel i_dut (.clk(clk), .arst_n(arst_n), .compare_control_reg(ctrl),
    .primary_compare_value(cmp_val), .match_primary(m_pri), .match_secondary(m_sec),
    .period_end(p_end), .fault_input_a(fault_a), .compare_output_pin(pin),
    .channel_irq(irq));
  ocm_pin_load i_load (.pin(pin), .gpio_level(gpio_level), .wire_level(wire_level));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic cmp_bit(input string name, input logic exp, input logic got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic cmp_cnt(input string name, input int exp, input int got);
    check_count++;
    if (got != exp) begin
      bad_count++;
      $display("mismatch %s expected %0d seen %0d", name, exp, got);
    end
  endtask

  // an unknown irq counts as a pulse so it cannot pass silently
  task automatic count_irq(input int n, output int cnt);
    cnt = 0;
    repeat (n) begin
      step(1);
      if (irq !== 1'b0) cnt++;
    end
  endtask

  // timer strobes are low here, so mode changes happen with the timer stopped
  task automatic set_mode(input logic [2:0] m, output int cnt);
    ctrl = {13'h0000, m};
    count_irq(3, cnt);
  endtask

  // only the raised strobe is lowered, so back-to-back pulses never drive
  // one signal twice in a time step
  task automatic pulse(input int which);
    if (which == 0) m_pri = 1'b1;
    else if (which == 1) m_sec = 1'b1;
    else p_end = 1'b1;
    step(1);
    if (which == 0) m_pri = 1'b0;
    else if (which == 1) m_sec = 1'b0;
    else p_end = 1'b0;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_entry();
    logic e;
    for (int k = 0; k < 2; k++) begin
      cmp_val = (k == 0) ? 16'h0000 : 16'h8001;
      foreach (modes[i]) begin
        set_mode(3'h0, c);
        set_mode(modes[i], c);
        e = (modes[i] == 3'h1) ? 1'b1 : (modes[i] >= 3'h6) ? (k == 1) : 1'b0;
        cmp_bit("entry_level", e, pin.level);
        cmp_bit("entry_drive", 1'b1, pin.drive);
        cmp_cnt("entry_irq", 0, c);
      end
    end
  endtask

  task automatic t_toggle(input logic [2:0] pre, input logic lvl);
    set_mode(3'h0, c);
    set_mode(pre, c);
    set_mode(3'h3, c);
    cmp_bit("toggle_keep", lvl, pin.level);
    for (int j = 0; j < 2; j++) begin
      lvl = ~lvl;
      pulse(0);
      cmp_bit("toggle_wire", lvl, wire_level);
      count_irq(3, c);
      cmp_cnt("toggle_irq", 1, c);
    end
  endtask

  task automatic t_delayed();
    set_mode(3'h0, c);
    set_mode(3'h4, c);
    pulse(0);
    cmp_bit("delay_high", 1'b1, pin.level);
    count_irq(3, c);
    cmp_cnt("delay_rise_irq", 0, c);
    pulse(1);
    cmp_bit("delay_low", 1'b0, pin.level);
    count_irq(3, c);
    cmp_cnt("delay_fall_irq", 1, c);
  endtask

  task automatic t_oneshot(input logic [2:0] m, input logic idle);
    set_mode(3'h0, c);
    set_mode(m, c);
    pulse(0);
    cmp_bit("shot_active", ~idle, pin.level);
    count_irq(3, c);
    cmp_bit("shot_idle", idle, pin.level);
    cmp_cnt("shot_irq", 1, c);
    pulse(0);
    count_irq(3, c);
    cmp_bit("shot_stay", idle, pin.level);
    cmp_cnt("shot_once", 0, c);
  endtask

  task automatic t_pulse();
    set_mode(3'h0, c);
    set_mode(3'h5, c);
    for (int j = 0; j < 2; j++) begin
      pulse(0);
      cmp_bit("pulse_high", 1'b1, pin.level);
      pulse(1);
      cmp_bit("pulse_low", 1'b0, pin.level);
      cmp_bit("pulse_rise_irq", 1'b0, irq);
      count_irq(3, c);
      cmp_cnt("pulse_irq", 1, c);
    end
  endtask

  task automatic t_fault();
    cmp_val = 16'h0001;
    set_mode(3'h0, c);
    set_mode(3'h7, c);
    fault_a = 1'b0;
    count_irq(3, c);
    cmp_cnt("fault_fall_irq", 1, c);
    fault_a = 1'b1;
    count_irq(3, c);
    cmp_cnt("fault_rise_irq", 0, c);
    set_mode(3'h6, c);
    fault_a = 1'b0;
    pulse(0);
    cmp_bit("pwm_clear", 1'b0, pin.level);
    cmp_bit("pwm_fault_irq", 1'b0, irq);
    pulse(2);
    cmp_bit("pwm_reload", 1'b1, pin.level);
    cmp_bit("pwm_fall_irq", 1'b0, irq);
    count_irq(3, c);
    cmp_cnt("pwm_irq", 0, c);
    fault_a = 1'b1;
  endtask

  task automatic t_off();
    set_mode(3'h0, c);
    cmp_bit("off_drive", 1'b0, pin.drive);
    for (int g = 0; g < 2; g++) begin
      gpio_level = g[0];
      fault_a = 1'b0;
      pulse(0);
      cmp_bit("off_fault_irq", 1'b0, irq);
      pulse(1);
      cmp_bit("off_match_irq", 1'b0, irq);
      fault_a = 1'b1;
      cmp_bit("off_wire", g[0], wire_level);
      count_irq(3, c);
      cmp_cnt("off_irq", 0, c);
    end
  endtask

  // ----------------------------------------
  // sequence and verdict
  // ----------------------------------------
  task automatic end_sim();
    if (bad_count == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    #20000;
    bad_count++;
    end_sim();
  end

  initial begin
    {arst_n, m_pri, m_sec, p_end, gpio_level} = 5'h00;
    ctrl = 16'h0000;
    cmp_val = 16'h0000;
    fault_a = 1'b1;
    repeat (2) @(posedge clk);
    #1 arst_n = 1'b1;
    cmp_bit("reset_drive", 1'b0, pin.drive);
    cmp_bit("reset_irq", 1'b0, irq);
    t_entry();
    t_toggle(3'h1, 1'b1);
    t_toggle(3'h2, 1'b0);
    t_oneshot(3'h1, 1'b1);
    t_oneshot(3'h2, 1'b0);
    t_delayed();
    t_pulse();
    t_fault();
    t_off();
    end_sim();
  end
endmodule
